// >>> core/pvic_arbiter.sv
// Picks the highest-priority requesting source, lowest number on ties.
// Assumes the request vector is already masked; source 0 is ignored.
`default_nettype none
module pvic_arbiter
  import pvic_pkg::*;
#(
  parameter int N = 32
)
(
  pvic_core_if.arb ab
);
  logic       f_c;
  logic [4:0] id_c;
  logic [2:0] lvl_c;
  always_comb
  begin
    f_c   = 1'b0;
    id_c  = 5'h00;
    lvl_c = 3'h0;
    for (int i = N - 1; i >= 1; i--)
    begin
      if (ab.req[i] && (!f_c || ab.prio[3*i +: 3] >= lvl_c)) // RQ16
      begin
        f_c   = 1'b1;
        id_c  = 5'(i);
        lvl_c = ab.prio[3*i +: 3]; // RQ12
      end
    end
  end
  assign ab.found = f_c;
  assign ab.id    = id_c;
  assign ab.level = lvl_c;
endmodule
`default_nettype wire

// >>> core/pvic_core_if.sv
// Bundle between controller, source input stage and arbiter.
// Assumes one clock; all signals are combinational levels.
`default_nettype none
interface pvic_core_if #(parameter int N = 32);
  logic [N-1:0]   raw;
  logic [2*N-1:0] trig;
  logic [N-1:0]   set;
  logic [N-1:0]   clr;
  logic [N-1:0]   pend;
  logic [N-1:0]   req;
  logic [3*N-1:0] prio;
  logic           found;
  logic [4:0]     id;
  logic [2:0]     level;
  modport src (input raw, trig, set, clr, output pend);
  modport arb (input req, prio, output found, id, level);
endinterface
`default_nettype wire

// >>> core/pvic_ctrl.sv
// Vectored priority interrupt controller with register port.
// Assumes synchronous inputs except lines flagged external.
`include "pvic_regs.svh"
`default_nettype none
module pvic_ctrl
  import pvic_pkg::*;
#(
  parameter int          N        = 32,
  parameter int          SYS_W    = 4,
  parameter logic [31:0] EXT_MASK = 32'h00000001
)
(
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             fast_interrupt_pin,
  input  wire logic [SYS_W-1:0] system_lines,
  input  wire logic [N-1:2]     source_lines,
  input  wire logic [8:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  output logic      [31:0]      rdata,
  output logic                  normal_request_n,
  output logic                  fast_request_n,
  output logic                  wake_request
);
  if (N < 3 || N > 32)
  begin : g_bad_n
    $error("pvic_ctrl: N must be 3 to 32");
  end
  localparam int SD = `PVIC_STACK_DEPTH;

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [2:0]     prio_q [N];
  logic [1:0]     trig_q [N];
  logic [31:0]    vec_q  [N];
  logic [N-1:0]   mask_q;
  logic [N-1:0]   ff_q;
  logic [31:0]    spur_q;
  logic [1:0]     gmask_q;
  pvic_frame_t    stack_q [SD];
  logic [3:0]     depth_q;
  logic           norm_n_q;
  logic           fast_n_q;
  logic           wake_q;
  logic [31:0]    rdata_q;
  logic [31:0]    rd_val;
  logic           in_smr;
  logic           in_svr;
  logic [4:0]     idx;
  logic           idx_ok;
  logic [N-1:0]   wd_n;
  logic [N-1:0]   one_n;
  logic           vec_rd;
  logic           fvr_rd;
  logic           eoi_wr;
  logic           push;
  logic [2:0]     top_idx;
  logic [2:0]     cur_lvl;
  logic [4:0]     cur_id;
  logic           irq_cond;
  logic           fiq_cond;
  logic [N-1:0]   auto_clr;

  pvic_core_if #(.N(N)) cb ();

  pvic_src_stage #(.N(N), .EXT_MASK(EXT_MASK)) u_src
  (
    .clock (clock),
    .nrst  (nrst),
    .sb    (cb)
  );

  pvic_arbiter #(.N(N)) u_arb
  (
    .ab (cb)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode

  assign in_smr = (addr[8:7] == `PVIC_SMR_BASE);
  assign in_svr = (addr[8:7] == `PVIC_SVR_BASE);
  assign idx    = addr[6:2];
  assign idx_ok = (int'(idx) < N);
  assign wd_n   = wdata[N-1:0];
  assign one_n  = {{(N-1){1'b0}}, 1'b1};
  assign vec_rd = rd_en && (addr == `PVIC_IVR);
  assign fvr_rd = rd_en && (addr == `PVIC_FVR);
  assign eoi_wr = wr_en && (addr == `PVIC_EOICR);

  ////////////////////////////////////////////////////////////////////////
  // Source routing

  // Source 0 pin, source 1 system OR, rest peripherals or pins
  assign cb.raw = {source_lines, // RQ23
                   |system_lines, // RQ22
                   fast_interrupt_pin}; // RQ21

  always_comb
  begin
    cb.trig = '0;
    cb.prio = '0;
    for (int i = 0; i < N; i++)
    begin
      cb.trig[2*i +: 2] = trig_q[i]; // RQ1
      cb.prio[3*i +: 3] = prio_q[i]; // RQ12
    end
  end

  assign cb.set = (wr_en && addr == `PVIC_ISCR) ? wd_n : '0; // RQ5
  // Auto clear skips fast-forced sources
  assign auto_clr = (push && !ff_q[cb.id]) ? (one_n << cb.id) : '0; // RQ7
  assign cb.clr = ((wr_en && addr == `PVIC_ICCR) ? wd_n : '0)
                | auto_clr // RQ6
                | (fvr_rd ? one_n : '0); // RQ8

  // Masked, fast-forced and source 0 kept out of arbitration
  assign cb.req = cb.pend & mask_q & ~ff_q & ~one_n; // RQ4 RQ11

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Clock never gated; every flop runs on each edge
  always_ff @(posedge clock) // RQ19
  begin
    if (!nrst)
    begin
      for (int i = 0; i < N; i++)
      begin
        prio_q[i] <= 3'h0;
        trig_q[i] <= 2'h0;
      end
    end
    else if (wr_en && in_smr && idx_ok)
    begin
      prio_q[idx] <= wdata[`PVIC_PRIO_LSB +: 3]; // RQ12
      trig_q[idx] <= wdata[`PVIC_TRIG_LSB +: 2]; // RQ1
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < N; i++)
        vec_q[i] <= `PVIC_WORD_RST;
    end
    else if (wr_en && in_svr && idx_ok)
      vec_q[idx] <= wdata;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      mask_q <= '0; // RQ28
    else if (wr_en && addr == `PVIC_IECR)
      mask_q <= mask_q | wd_n; // RQ3
    else if (wr_en && addr == `PVIC_IDCR)
      mask_q <= mask_q & ~wd_n; // RQ3
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      ff_q <= '0;
    else if (wr_en && addr == `PVIC_FFER)
      ff_q <= (ff_q | wd_n) & ~one_n; // RQ24
    else if (wr_en && addr == `PVIC_FFDR)
      ff_q <= ff_q & ~wd_n;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      spur_q  <= `PVIC_WORD_RST;
      gmask_q <= 2'h0;
    end
    else if (wr_en && addr == `PVIC_SPUR)
      spur_q <= wdata;
    else if (wr_en && addr == `PVIC_GMASK)
      gmask_q <= wdata[1:0]; // RQ20
  end

  ////////////////////////////////////////////////////////////////////////
  // Priority stack

  assign top_idx = 3'(depth_q - 4'h1);
  assign cur_lvl = stack_q[top_idx].level; // RQ15
  assign cur_id  = (depth_q != 4'h0) ? stack_q[top_idx].id : 5'h00;

  // Only a strictly higher level may preempt the current one
  assign irq_cond = cb.found
                 && (depth_q == 4'h0 || cb.level > cur_lvl); // RQ17
  // Choice made at the read itself, not when raised
  assign push = vec_rd && irq_cond && (depth_q < 4'(SD)); // RQ14

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      depth_q <= 4'h0; // RQ28
      for (int i = 0; i < SD; i++)
        stack_q[i] <= '0;
    end
    else if (push)
    begin
      stack_q[3'(depth_q)] <= '{level: cb.level, id: cb.id}; // RQ25
      depth_q <= depth_q + 4'h1; // RQ15
    end
    else if (eoi_wr && depth_q != 4'h0)
      depth_q <= depth_q - 4'h1; // RQ26
  end

  ////////////////////////////////////////////////////////////////////////
  // Request outputs

  assign fiq_cond = |(cb.pend & mask_q & (ff_q | one_n)); // RQ24

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      norm_n_q <= 1'b1; // RQ28
      fast_n_q <= 1'b1; // RQ28
      wake_q   <= 1'b0;
    end
    else
    begin
      // Lower requests wait here until the stack is popped
      norm_n_q <= !(irq_cond && !gmask_q[0] && !vec_rd); // RQ13 RQ18
      fast_n_q <= !(fiq_cond && !gmask_q[1]); // RQ24
      wake_q   <= irq_cond || fiq_cond; // RQ20
    end
  end

  assign normal_request_n = norm_n_q;
  assign fast_request_n   = fast_n_q;
  assign wake_request     = wake_q;

  ////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb
  begin
    rd_val = 32'h00000000;
    case (addr)
      `PVIC_IVR:   rd_val = push ? vec_q[cb.id] : spur_q; // RQ25
      `PVIC_FVR:   rd_val = vec_q[0];
      `PVIC_ISR:   rd_val = {27'h0000000, cur_id}; // RQ10
      `PVIC_IPR:   rd_val = 32'(cb.pend); // RQ9
      `PVIC_IMR:   rd_val = 32'(mask_q); // RQ3
      `PVIC_CISR:  rd_val = {30'h00000000, ~fast_n_q, ~norm_n_q}; // RQ10
      `PVIC_SPUR:  rd_val = spur_q;
      `PVIC_GMASK: rd_val = {30'h00000000, gmask_q};
      `PVIC_FFSR:  rd_val = 32'(ff_q);
      default:
      begin
        if (in_smr && idx_ok)
          rd_val = {25'h0000000, trig_q[idx], 2'h0, prio_q[idx]};
        else if (in_svr && idx_ok)
          rd_val = vec_q[idx];
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      rdata_q <= `PVIC_WORD_RST;
    else if (rd_en)
      rdata_q <= rd_val;
    else
      rdata_q <= `PVIC_WORD_RST;
  end

  assign rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  mask_en_a: assert property (@(posedge clock) disable iff (!nrst) // RQ3
    (wr_en && addr == `PVIC_IECR) |=> ((mask_q & $past(wd_n)) == $past(wd_n)))
    else $error("enable command did not set mask bits");

  mask_dis_a: assert property (@(posedge clock) disable iff (!nrst) // RQ3
    (wr_en && addr == `PVIC_IDCR) |=> ((mask_q & $past(wd_n)) == '0))
    else $error("disable command did not clear mask bits");

  masked_quiet_a: assert property (@(posedge clock) disable iff (!nrst) // RQ4
    ((cb.pend & mask_q) == '0) |=> (normal_request_n && fast_request_n))
    else $error("request raised with no enabled pending source");

  ff_noclr_a: assert property (@(posedge clock) disable iff (!nrst) // RQ7
    vec_rd |-> ((cb.clr & ff_q) == '0))
    else $error("vector read cleared a fast-forced source");

  fvr_clr_a: assert property (@(posedge clock) disable iff (!nrst) // RQ8
    fvr_rd |-> cb.clr[0])
    else $error("fast vector read did not clear source 0");

  core_img_a: assert property (@(posedge clock) disable iff (!nrst) // RQ10
    (rd_en && addr == `PVIC_CISR)
      |=> (rdata[1:0] == ~{$past(fast_request_n), $past(normal_request_n)}))
    else $error("core status does not mirror request lines");

  push_lvl_a: assert property (@(posedge clock) disable iff (!nrst) // RQ15
    push |=> (depth_q == $past(depth_q) + 4'h1
              && cur_lvl == $past(cb.level)))
    else $error("vector read did not push chosen level");

  eoi_pop_a: assert property (@(posedge clock) disable iff (!nrst) // RQ26
    (eoi_wr && depth_q != 4'h0) |=> (depth_q == $past(depth_q) - 4'h1))
    else $error("end of service did not pop the stack");

  vec_drop_a: assert property (@(posedge clock) disable iff (!nrst) // RQ25
    vec_rd |=> normal_request_n)
    else $error("normal request not dropped after vector read");

  nest_gate_a: assert property (@(posedge clock) disable iff (!nrst) // RQ17
    (!normal_request_n && $past(depth_q) != 4'h0)
      |-> ($past(cb.level) > $past(cur_lvl)))
    else $error("request raised without higher priority");

  ff_route_a: assert property (@(posedge clock) disable iff (!nrst) // RQ24
    ((|(cb.pend & mask_q & ff_q)) && !gmask_q[1]) |=> !fast_request_n)
    else $error("fast-forced source did not raise fast request");

  rst_quiet_a: assert property (@(posedge clock) // RQ28
    !nrst |=> (normal_request_n && fast_request_n
               && mask_q == '0 && depth_q == 4'h0))
    else $error("reset left a request or mask active");

  wake_mirror_a: assert property (@(posedge clock) disable iff (!nrst) // RQ20
    (!normal_request_n || !fast_request_n) |-> wake_request)
    else $error("request line low without wake");

  sel_ok_a: assert property (@(posedge clock) disable iff (!nrst) // RQ11
    push |-> (cb.id != 5'h00 && !ff_q[cb.id]
              && mask_q[cb.id] && cb.pend[cb.id]))
    else $error("vector read chose an ineligible source");

endmodule
`default_nettype wire

// >>> core/pvic_pkg.sv
// Types shared by the controller modules.
// Assumes the constants header is on the include path.
`default_nettype none
package pvic_pkg;
  typedef enum logic [1:0]
  {
    PVIC_LVL_LOW   = 2'h0,
    PVIC_LVL_HIGH  = 2'h1,
    PVIC_EDGE_FALL = 2'h2,
    PVIC_EDGE_RISE = 2'h3
  } pvic_trig_t;
  typedef struct packed
  {
    logic [2:0] level;
    logic [4:0] id;
  } pvic_frame_t;
endpackage
`default_nettype wire

// >>> core/pvic_regs.svh
// Offsets, field positions, reset values and sizes of the controller.
// Assumes a 9-bit byte address; every register is one 32-bit word.
// Function
// RQ1 - Each source's trigger-type field selects level or edge detection.
// RQ2 - External sources: high level, low level, rising or falling edge.
// RQ3 - Enable and disable command writes set the mask, readable back.
// RQ4 - A masked source never affects arbitration, requests or service.
// RQ5 - Set and clear commands change edge latches only, not level sources.
// RQ6 - Vector read clears the latched edge of the chosen source only.
// RQ7 - Fast-forced sources are never cleared by a vector read.
// RQ8 - Fast vector read clears the latched edge of source 0.
// RQ9 - Pending shows all source activity; mask shows enabled sources.
// RQ10 - Status gives current number; core status mirrors both request outputs.
// RQ11 - Eight-level priority logic drives normal request from sources 1 to 31.
// RQ12 - Three-bit priority per source, 7 highest and 0 lowest.
// RQ13 - Normal request rises once an enabled source triggers and priority allows.
// RQ14 - Current source is chosen at vector read; software must read it.
// RQ15 - Current level equals priority of the most recently chosen source.
// RQ16 - Ties at highest priority go to the lowest source number.
// RQ17 - During service only strictly higher priority may raise the request.
// RQ18 - Equal or lower requests wait for the end-of-service write.
// RQ19 - Runs on a free clock, unaffected by power-management gating.
// RQ20 - Either request wakes the core; global mask allows wake alone.
// RQ21 - Source 0 is the fast interrupt pin.
// RQ22 - Source 1 is the OR of the system peripheral lines.
// RQ23 - Sources 2 to 31 are peripheral outputs or external lines.
// RQ24 - Fast-forced sources drive the fast request, not the normal one.
// RQ25 - Vector read drops request, pushes level and number, returns vector.
// RQ26 - End-of-service write pops the eight-deep stack.
// RQ27 - External inputs pass two synchroniser flops before detection.
// RQ28 - Reset masks all, clears latches, empties stack, requests high.
`ifndef PVIC_REGS_SVH
`define PVIC_REGS_SVH
`define PVIC_SMR_BASE 2'h0
`define PVIC_SVR_BASE 2'h1
`define PVIC_IVR      9'h100
`define PVIC_FVR      9'h104
`define PVIC_ISR      9'h108
`define PVIC_IPR      9'h10C
`define PVIC_IMR      9'h110
`define PVIC_CISR     9'h114
`define PVIC_IECR     9'h120
`define PVIC_IDCR     9'h124
`define PVIC_ICCR     9'h128
`define PVIC_ISCR     9'h12C
`define PVIC_EOICR    9'h130
`define PVIC_SPUR     9'h134
`define PVIC_GMASK    9'h138
`define PVIC_FFER     9'h140
`define PVIC_FFDR     9'h144
`define PVIC_FFSR     9'h148
`define PVIC_PRIO_LSB 0
`define PVIC_TRIG_LSB 5
`define PVIC_WORD_RST 32'h00000000
`define PVIC_STACK_DEPTH 8
`endif

// >>> core/pvic_src_stage.sv
// Input stage for every source: synchroniser on external lines only, detection, edge latch.
// Assumes internal lines are synchronous and active high.
`default_nettype none
module pvic_src_stage
  import pvic_pkg::*;
#(
  parameter int          N        = 32,
  parameter logic [31:0] EXT_MASK = 32'h00000001
)
(
  input wire logic clock,
  input wire logic nrst,
  pvic_core_if.src sb
);
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_src
      logic line;
      logic pol;
      logic mode;
      logic act;
      logic prev_q;
      logic edge_q;
      logic hit;
      if (EXT_MASK[i])
      begin : g_ext
        logic s1_q;
        logic s2_q;
        always_ff @(posedge clock)
        begin
          s1_q <= sb.raw[i]; // RQ27
          s2_q <= s1_q; // RQ27
        end
        assign line = s2_q;
        assign pol  = sb.trig[2*i]; // RQ2
      end
      else
      begin : g_int
        assign line = sb.raw[i];
        assign pol  = 1'b1; // RQ1
      end
      assign mode = sb.trig[2*i+1]; // RQ1
      assign act  = pol ? line : ~line; // RQ2
      assign hit  = pol ? (line & ~prev_q) : (~line & prev_q); // RQ2
      always_ff @(posedge clock)
      begin
        if (!nrst)
          prev_q <= 1'b0;
        else
          prev_q <= line;
      end
      // Edge latch, set wins over clear
      always_ff @(posedge clock)
      begin
        if (!nrst)
          edge_q <= 1'b0; // RQ28
        else if (!mode)
          edge_q <= 1'b0; // RQ5
        else if (hit || sb.set[i])
          edge_q <= 1'b1; // RQ5
        else if (sb.clr[i])
          edge_q <= 1'b0; // RQ5
      end
      assign sb.pend[i] = mode ? edge_q : act; // RQ9
      edge_set_a: assert property (@(posedge clock) disable iff (!nrst) // RQ5
        (sb.set[i] && mode) |=> edge_q)
        else $error("set command did not latch edge source");
    end
  endgenerate
endmodule
`default_nettype wire

// >>> sim/pvic_ctrl_tb.sv
// Self-checking bench for the vectored interrupt controller.
// Assumes the constants header is on the include path.
`include "pvic_regs.svh"
`default_nettype none
module pvic_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock;
  logic        nrst;
  logic [31:0] lvl;
  logic        fast_pin;
  logic [3:0]  system_source;
  logic [31:2] src;
  logic [8:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata;
  logic        nrq_n;
  logic        frq_n;
  logic        wake;
  int          errors;
  int          n_tests;

  pvic_ctrl DUT
  (
    .clock              (clock),
    .nrst               (nrst),
    .fast_interrupt_pin (fast_pin),
    .system_lines       (system_source),
    .source_lines       (src),
    .addr               (addr),
    .wdata              (wdata),
    .wr_en              (wr_en),
    .rd_en              (rd_en),
    .rdata              (rdata),
    .normal_request_n   (nrq_n),
    .fast_request_n     (frq_n),
    .wake_request       (wake)
  );

  pvic_line_model u_lines
  (
    .clock    (clock),
    .lvl      (lvl),
    .fast_pin (fast_pin),
    .system_source      (system_source),
    .src      (src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic line(input int i, input logic v);
    @(posedge clock);
    lvl[i] <= v;
  endtask

  task automatic cfg(input int i, input logic [31:0] m);
    wr(9'(4 * i), m);
    wr(9'(128 + 4 * i), 32'hA0 + i);
    wr(`PVIC_IECR, 32'h1 << i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial
  begin
    nrst    = 1'b0;
    // Fast pin idles high, inactive for its low-level reset mode
    lvl     = 32'h00000001;
    addr    = 9'h000;
    wdata   = 32'h0;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    errors  = 0;
    n_tests = 0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    cyc(1);
    chk(32'(nrq_n), 32'h1);
    chk(32'(frq_n), 32'h1);
    rd(`PVIC_IMR, 32'h0);
    rd(`PVIC_IPR, 32'h0);
    rd(`PVIC_ISR, 32'h0);
    rd(`PVIC_CISR, 32'h0);
    rd(9'h1FC, 32'h0);
    wr(`PVIC_SPUR, 32'h5F);
    // Single edge source and its service
    cfg(5, 32'h63);
    cfg(6, 32'h23);
    cfg(7, 32'h65);
    line(5, 1'b1);
    line(5, 1'b0);
    cyc(4);
    chk(32'(nrq_n), 32'h0);
    rd(`PVIC_IPR, 32'h20);
    rd(`PVIC_CISR, 32'h1);
    rd(`PVIC_IVR, 32'hA5);
    chk(32'(nrq_n), 32'h1);
    rd(`PVIC_IPR, 32'h0);
    rd(`PVIC_ISR, 32'h5);
    // Nesting: equal level held, higher level preempts
    line(6, 1'b1);
    cyc(4);
    chk(32'(nrq_n), 32'h1);
    line(7, 1'b1);
    line(7, 1'b0);
    cyc(4);
    chk(32'(nrq_n), 32'h0);
    rd(`PVIC_IVR, 32'hA7);
    rd(`PVIC_ISR, 32'h7);
    wr(`PVIC_EOICR, 32'h0);
    rd(`PVIC_ISR, 32'h5);
    chk(32'(nrq_n), 32'h1);
    wr(`PVIC_EOICR, 32'h0);
    cyc(2);
    chk(32'(nrq_n), 32'h0);
    rd(`PVIC_IVR, 32'hA6);
    line(6, 1'b0);
    wr(`PVIC_EOICR, 32'h0);
    // Tie at equal level, set and clear commands
    cfg(8, 32'h64);
    cfg(9, 32'h64);
    wr(`PVIC_ISCR, 32'h300);
    cyc(2);
    rd(`PVIC_IPR, 32'h300);
    rd(`PVIC_IVR, 32'hA8);
    rd(`PVIC_IPR, 32'h200);
    wr(`PVIC_EOICR, 32'h0);
    wr(`PVIC_ICCR, 32'h200);
    rd(`PVIC_IPR, 32'h0);
    wr(`PVIC_ISCR, 32'h40);
    rd(`PVIC_IPR, 32'h0);
    // Masked source
    wr(`PVIC_ISCR, 32'h200);
    wr(`PVIC_IDCR, 32'h200);
    rd(`PVIC_IMR, 32'h1E0);
    cyc(2);
    chk(32'(nrq_n), 32'h1);
    rd(`PVIC_IPR, 32'h200);
    rd(`PVIC_IVR, 32'h5F);
    wr(`PVIC_ICCR, 32'h200);
    // Fast forcing
    wr(`PVIC_FFER, 32'h100);
    rd(`PVIC_FFSR, 32'h100);
    wr(`PVIC_ISCR, 32'h100);
    cyc(2);
    chk(32'(frq_n), 32'h0);
    chk(32'(nrq_n), 32'h1);
    rd(`PVIC_IVR, 32'h5F);
    rd(`PVIC_IPR, 32'h100);
    wr(`PVIC_FFDR, 32'h100);
    wr(`PVIC_ICCR, 32'h100);
    // Fast pin in all four trigger modes
    wr(9'h080, 32'hA0);
    wr(`PVIC_IECR, 32'h1);
    for (int t = 0; t < 4; t++)
    begin
      wr(9'h000, 32'(t) << 5);
      line(0, ~t[0]);
      cyc(6);
      wr(`PVIC_ICCR, 32'h1);
      rd(`PVIC_IPR, 32'h0);
      line(0, t[0]);
      cyc(6);
      rd(`PVIC_IPR, 32'h1);
      chk(32'(frq_n), 32'h0);
      if (t[1])
      begin
        rd(`PVIC_FVR, 32'hA0);
        rd(`PVIC_IPR, 32'h0);
      end
    end
    wr(`PVIC_IDCR, 32'h1);
    // System source
    line(1, 1'b1);
    cyc(3);
    rd(`PVIC_IPR, 32'h2);
    line(1, 1'b0);
    // Global mask keeps wake only
    cfg(11, 32'h22);
    wr(`PVIC_GMASK, 32'h1);
    line(11, 1'b1);
    cyc(4);
    chk(32'(nrq_n), 32'h1);
    chk(32'(wake), 32'h1);
    wr(`PVIC_GMASK, 32'h0);
    cyc(2);
    chk(32'(nrq_n), 32'h0);
    rd(`PVIC_IVR, 32'hAB);
    line(11, 1'b0);
    wr(`PVIC_EOICR, 32'h0);
    cyc(2);
    complete_run();
  end
endmodule
`default_nettype wire

// >>> sim/pvic_line_model.sv
// Model of the pins and peripherals that feed the controller's sources.
// Assumes the bench sets line levels; lines change on the clock edge.
`default_nettype none
module pvic_line_model
(
  input  wire logic        clock,
  input  wire logic [31:0] lvl,
  output logic             fast_pin,
  output logic [3:0]       system_source,
  output logic [31:2]      src
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // Line drivers
  always_ff @(posedge clock)
  begin
    fast_pin <= lvl[0];
    system_source      <= {1'b0, lvl[1], 2'b00};
    src      <= lvl[31:2];
  end
endmodule
`default_nettype wire
